// ===== hw/sdram_cfg_defines.vh
// register map, field positions, reset values and timing counts for the sdram config block
`ifndef SDRAM_CFG_DEFINES_VH
`define SDRAM_CFG_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_FIRST_ROW_POP 8'h4C
`define OFS_SDRAM_TIMING 8'h50
`define OFS_THIRD_SOCKET_POP 8'h54
`define OFS_HOLE_CONTROL 8'h58
`define OFS_LOCK_STATUS 8'h60

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_FIRST_ROW_POP 8'h00
`define RST_SDRAM_TIMING 3'h0
`define RST_THIRD_SOCKET_POP 4'h0
`define RST_HOLE_ENABLE 1'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TIM_PRECHARGE_BIT 0
`define TIM_ACT_DELAY_BIT 1
`define TIM_READ_LAT_BIT 2
`define POP_FIELD_MSB 3
`define HOLE_ENABLE_BIT 7
`define LOCK_BIT 0
`define STAT_OVER_BIT 1
`define STAT_ROW_OPEN_BIT 2
`define STAT_TOTAL_LSB 4
`define STAT_TOTAL_MSB 13

// ----------------------------------------------------------------
// sdram timing counts in sdram clocks
// ----------------------------------------------------------------
`define READ_LAT_LONG_CLK 2'h3
`define READ_LAT_SHORT_CLK 2'h2
`define ACT_GAP_LONG_CLK 2'h3
`define ACT_GAP_SHORT_CLK 2'h2
`define PRECHARGE_LONG_CLK 2'h3
`define PRECHARGE_SHORT_CLK 2'h2

// ----------------------------------------------------------------
// memory map limits, in megabytes
// ----------------------------------------------------------------
`define MAX_MEMORY_MB 10'h200
`define HOLE_BASE_MB 12'h00F
`define SIDE_MB_SMALL 10'h020
`define SIDE_MB_MID 10'h040
`define SIDE_MB_LARGE 10'h080

// ----------------------------------------------------------------
// command codes on the request port and the sdram command outputs
// ----------------------------------------------------------------
`define CMD_ACTIVATE 2'h0
`define CMD_READ 2'h1
`define CMD_WRITE 2'h2
`define CMD_PRECHARGE 2'h3

`endif

// ===== hw/sdram_gap_timer.v
// countdown timer that spaces sdram commands
`timescale 1ns/1ps
module sdram_gap_timer (
  input wire i_mclk,
  input wire i_reset,
  input wire i_load,
  input wire [1:0] i_count,
  output wire o_zero
);

  reg [1:0] count_reg;
  reg [1:0] count_next;

  // load on a command, otherwise count down to zero and hold
  always @* begin
    count_next = count_reg;
    if (i_load) begin
      count_next = i_count;
    end else if (count_reg != 2'h0) begin
      count_next = count_reg - 2'h1;
    end
  end

  // counter flop
  always @(posedge i_mclk) begin
    if (i_reset) begin
      count_reg <= 2'h0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_zero = (count_reg == 2'h0); // next command may be decided this cycle

endmodule

// ===== hw/memory_hole_decode.v
// address decode for main memory with the fixed 15-16 MB hole
`timescale 1ns/1ps
`include "sdram_cfg_defines.vh"
module memory_hole_decode (
  input wire [31:0] i_addr,
  input wire i_hole_enable,
  input wire [9:0] i_top_mb,
  output wire o_in_hole,
  output wire o_to_dram
);

  wire [11:0] addr_mb;

  // megabyte index of the address; the hole is exactly one megabyte
  assign addr_mb = i_addr[31:20];
  assign o_in_hole = i_hole_enable && (addr_mb == `HOLE_BASE_MB); // see RULE_08

  // dram only below the populated top and outside an enabled hole
  assign o_to_dram = !o_in_hole && (addr_mb < {2'h0, i_top_mb}); // see RULE_11

endmodule

// ===== hw/sdram_timing_row_hole_config.v
// sdram timing, row population and fixed memory hole configuration block
// Operation
// RULE_01: read data sampled 3 clocks after read, or 2 when latency select set
// RULE_02: activate to read/write gap is 3 clocks, or 2 when delay select set
// RULE_03: precharge lasts 3 clocks, or 2 when precharge select set
// RULE_04: third-socket population writable until lock bit set, then read-only
// RULE_05: six 64-bit rows in three sockets; third socket field bits 3:0
// RULE_06: total populated memory never exceeds 512 MB; only third-socket writes are refused, first-row writes can pass it
// RULE_07: software lowers 133 MHz to 100 MHz when too many modules fitted
// RULE_08: enabled hole sends host cycles at 15-16 MB to the hub link
// RULE_09: enabled hole leaves hub-link and PCI cycles there unclaimed
// RULE_10: dram behind the hole is not relocated anywhere
// RULE_11: with hole disabled, 15-16 MB decodes to dram like other memory
`timescale 1ns/1ps
`include "sdram_cfg_defines.vh"
module sdram_timing_row_hole_config (
  input wire i_mclk,
  input wire i_reset,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_cmd_valid,
  input wire [1:0] i_cmd_code,
  output wire o_cmd_ack,
  output wire o_sdram_cmd_valid,
  output wire [1:0] o_sdram_cmd,
  output wire o_read_sample,
  input wire i_host_valid,
  input wire [31:0] i_host_addr,
  output wire o_host_to_dram,
  output wire o_host_to_hub,
  output wire [31:0] o_host_addr,
  input wire i_init_valid,
  input wire [31:0] i_init_addr,
  output wire o_init_claim
);

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  localparam ST_CLOSED = 1'b0;
  localparam ST_OPEN = 1'b1;

  // ----------------------------------------------------------------
  // capacity functions
  // ----------------------------------------------------------------

  // size of one side of a module from its 2-bit size code
  function [9:0] side_mb;
    input [1:0] code;
    begin
      case (code)
        2'h1: side_mb = `SIDE_MB_SMALL;
        2'h2: side_mb = `SIDE_MB_MID;
        2'h3: side_mb = `SIDE_MB_LARGE;
        default: side_mb = 10'h000;
      endcase
    end
  endfunction

  // size of one module: low pair is the front side, high pair the back side
  function [9:0] dimm_mb;
    input [3:0] field;
    begin
      dimm_mb = side_mb(field[1:0]) + side_mb(field[3:2]);
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] first_row_population_register;
  reg [3:0] third_socket_row_population;
  reg hole_enable;
  reg read_latency_select;
  reg activate_to_command_delay_select;
  reg precharge_length_select;
  reg config_lock_bit;
  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg state_reg;
  reg state_next;
  reg cmd_ack_reg;
  reg sdram_cmd_valid_reg;
  reg [1:0] sdram_cmd_reg;
  reg [2:0] read_shift_reg;
  reg read_sample_reg;
  reg host_to_dram_reg;
  reg host_to_hub_reg;
  reg [31:0] host_addr_reg;
  reg init_claim_reg;

  wire [9:0] total_mb;
  wire [9:0] total_with_new_mb;
  wire over_limit;
  wire apb_setup;
  wire apb_write;
  wire wr_over_limit;
  wire addr_mapped;
  wire rcd_zero;
  wire trp_zero;
  wire host_in_hole;
  wire host_dram;
  wire init_in_hole;
  wire init_dram;
  reg issue;
  reg [31:0] read_mux;
  reg slverr_mux;

  // ----------------------------------------------------------------
  // populated capacity
  // ----------------------------------------------------------------

  // total of all three sockets, and what it would be after a pending third-socket write
  assign total_mb = dimm_mb(first_row_population_register[3:0])
                  + dimm_mb(first_row_population_register[7:4])
                  + dimm_mb(third_socket_row_population); // see RULE_05
  assign total_with_new_mb = dimm_mb(first_row_population_register[3:0])
                           + dimm_mb(first_row_population_register[7:4])
                           + dimm_mb(i_pwdata[`POP_FIELD_MSB:0]);
  assign over_limit = (total_mb > `MAX_MEMORY_MB); // see RULE_06

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign apb_setup = i_psel && !i_penable;
  assign apb_write = i_psel && i_penable && i_pwrite && !pslverr_reg;

  // a third-socket population write that would push the total past the limit is refused
  assign wr_over_limit = i_pwrite && !config_lock_bit
                      && (i_paddr == `OFS_THIRD_SOCKET_POP)
                      && (total_with_new_mb > `MAX_MEMORY_MB); // see RULE_06

  assign addr_mapped = (i_paddr == `OFS_FIRST_ROW_POP)
                    || (i_paddr == `OFS_SDRAM_TIMING)
                    || (i_paddr == `OFS_THIRD_SOCKET_POP)
                    || (i_paddr == `OFS_HOLE_CONTROL)
                    || (i_paddr == `OFS_LOCK_STATUS);

  // read data and error for the transfer now in its setup cycle
  always @* begin
    read_mux = 32'h00000000;
    slverr_mux = !addr_mapped || wr_over_limit;
    case (i_paddr)
      `OFS_FIRST_ROW_POP: begin
        read_mux[7:0] = first_row_population_register;
      end
      `OFS_SDRAM_TIMING: begin
        read_mux[`TIM_PRECHARGE_BIT] = precharge_length_select;
        read_mux[`TIM_ACT_DELAY_BIT] = activate_to_command_delay_select;
        read_mux[`TIM_READ_LAT_BIT] = read_latency_select;
      end
      `OFS_THIRD_SOCKET_POP: begin
        read_mux[`POP_FIELD_MSB:0] = third_socket_row_population; // upper bits reserved
      end
      `OFS_HOLE_CONTROL: begin
        read_mux[`HOLE_ENABLE_BIT] = hole_enable;
      end
      `OFS_LOCK_STATUS: begin
        read_mux[`LOCK_BIT] = config_lock_bit;
        read_mux[`STAT_OVER_BIT] = over_limit;
        read_mux[`STAT_ROW_OPEN_BIT] = state_reg;
        read_mux[`STAT_TOTAL_MSB:`STAT_TOTAL_LSB] = total_mb;
      end
      default: begin
        read_mux = 32'h00000000;
      end
    endcase
  end

  // bus answer flops: data and error latched in setup, ready after reset
  always @(posedge i_mclk) begin
    if (i_reset) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (apb_setup) begin
        prdata_reg <= read_mux;
        pslverr_reg <= slverr_mux;
      end
    end
  end

  // register writes take effect at the access edge
  always @(posedge i_mclk) begin
    if (i_reset) begin
      first_row_population_register <= `RST_FIRST_ROW_POP;
      third_socket_row_population <= `RST_THIRD_SOCKET_POP;
      hole_enable <= `RST_HOLE_ENABLE;
      read_latency_select <= (`RST_SDRAM_TIMING >> `TIM_READ_LAT_BIT) != 3'h0;
      activate_to_command_delay_select <= 1'b0;
      precharge_length_select <= 1'b0;
      config_lock_bit <= 1'b0;
    end else if (apb_write) begin
      case (i_paddr)
        `OFS_FIRST_ROW_POP: begin
          if (!config_lock_bit) begin
            first_row_population_register <= i_pwdata[7:0];
          end
        end
        `OFS_SDRAM_TIMING: begin
          read_latency_select <= i_pwdata[`TIM_READ_LAT_BIT];
          activate_to_command_delay_select <= i_pwdata[`TIM_ACT_DELAY_BIT];
          precharge_length_select <= i_pwdata[`TIM_PRECHARGE_BIT];
        end
        `OFS_THIRD_SOCKET_POP: begin
          if (!config_lock_bit) begin // see RULE_04
            third_socket_row_population <= i_pwdata[`POP_FIELD_MSB:0]; // see RULE_05
          end
        end
        `OFS_HOLE_CONTROL: begin
          hole_enable <= i_pwdata[`HOLE_ENABLE_BIT]; // see RULE_08
        end
        `OFS_LOCK_STATUS: begin
          if (i_pwdata[`LOCK_BIT]) begin
            config_lock_bit <= 1'b1; // see RULE_04
          end
        end
        default: begin
          config_lock_bit <= config_lock_bit;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sdram command spacing
  // ----------------------------------------------------------------

  // activate-to-command gap: this many idle clocks follow the activate before a read/write goes out
  sdram_gap_timer u_rcd_timer (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_load(issue && (i_cmd_code == `CMD_ACTIVATE)),
    .i_count(activate_to_command_delay_select ? `ACT_GAP_SHORT_CLK
                                               : `ACT_GAP_LONG_CLK), // see RULE_02
    .o_zero(rcd_zero)
  );

  // precharge period: the next activate lands that many clocks after it
  sdram_gap_timer u_trp_timer (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_load(issue && (i_cmd_code == `CMD_PRECHARGE)),
    .i_count(precharge_length_select ? (`PRECHARGE_SHORT_CLK - 2'h1)
                                     : (`PRECHARGE_LONG_CLK - 2'h1)), // see RULE_03
    .o_zero(trp_zero)
  );

  // decide whether the held request may go out this cycle
  always @* begin
    issue = 1'b0;
    state_next = state_reg;
    case (state_reg)
      ST_CLOSED: begin
        if (i_cmd_valid && !cmd_ack_reg && trp_zero) begin
          if (i_cmd_code == `CMD_ACTIVATE) begin
            issue = 1'b1; // see RULE_03
            state_next = ST_OPEN;
          end else if (i_cmd_code == `CMD_PRECHARGE) begin
            issue = 1'b1;
          end
        end
      end
      ST_OPEN: begin
        if (i_cmd_valid && !cmd_ack_reg && rcd_zero) begin
          if (i_cmd_code == `CMD_READ || i_cmd_code == `CMD_WRITE) begin
            issue = 1'b1; // see RULE_02
          end else if (i_cmd_code == `CMD_PRECHARGE) begin
            issue = 1'b1;
            state_next = ST_CLOSED;
          end
        end
      end
      default: begin
        state_next = ST_CLOSED;
      end
    endcase
  end

  // command outputs and acknowledge
  always @(posedge i_mclk) begin
    if (i_reset) begin
      state_reg <= ST_CLOSED;
      cmd_ack_reg <= 1'b0;
      sdram_cmd_valid_reg <= 1'b0;
      sdram_cmd_reg <= `CMD_ACTIVATE;
    end else begin
      state_reg <= state_next;
      cmd_ack_reg <= issue;
      sdram_cmd_valid_reg <= issue;
      if (issue) begin
        sdram_cmd_reg <= i_cmd_code;
      end
    end
  end

  // read sample strobe trails the read command by the selected latency
  always @(posedge i_mclk) begin
    if (i_reset) begin
      read_shift_reg <= 3'h0;
      read_sample_reg <= 1'b0;
    end else begin
      read_shift_reg <= {read_shift_reg[1:0], issue && (i_cmd_code == `CMD_READ)};
      read_sample_reg <= read_latency_select ? read_shift_reg[1]
                                             : read_shift_reg[2]; // see RULE_01
    end
  end

  // ----------------------------------------------------------------
  // address routing
  // ----------------------------------------------------------------

  // host cycles
  memory_hole_decode u_host_decode (
    .i_addr(i_host_addr),
    .i_hole_enable(hole_enable),
    .i_top_mb(total_mb),
    .o_in_hole(host_in_hole),
    .o_to_dram(host_dram)
  );

  // hub-link and pci initiator cycles
  memory_hole_decode u_init_decode (
    .i_addr(i_init_addr),
    .i_hole_enable(hole_enable),
    .i_top_mb(total_mb),
    .o_in_hole(init_in_hole),
    .o_to_dram(init_dram)
  );

  // route each cycle; the address is passed through untranslated
  always @(posedge i_mclk) begin
    if (i_reset) begin
      host_to_dram_reg <= 1'b0;
      host_to_hub_reg <= 1'b0;
      host_addr_reg <= 32'h00000000;
      init_claim_reg <= 1'b0;
    end else begin
      host_to_dram_reg <= i_host_valid && host_dram; // see RULE_11
      host_to_hub_reg <= i_host_valid && (host_in_hole || !host_dram); // see RULE_08
      host_addr_reg <= i_host_addr; // see RULE_10
      init_claim_reg <= i_init_valid && !init_in_hole && init_dram; // see RULE_09
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_cmd_ack = cmd_ack_reg;
  assign o_sdram_cmd_valid = sdram_cmd_valid_reg;
  assign o_sdram_cmd = sdram_cmd_reg;
  assign o_read_sample = read_sample_reg;
  assign o_host_to_dram = host_to_dram_reg;
  assign o_host_to_hub = host_to_hub_reg;
  assign o_host_addr = host_addr_reg;
  assign o_init_claim = init_claim_reg;

endmodule

// ===== test/sdram_cfg_properties.sv
// port assertions for the sdram timing, population and hole block
`timescale 1ns/1ps
`include "sdram_cfg_defines.vh"
module sdram_cfg_properties (
  input wire i_mclk,
  input wire i_reset,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire o_cmd_ack,
  input wire o_sdram_cmd_valid,
  input wire [1:0] o_sdram_cmd,
  input wire o_read_sample,
  input wire i_host_valid,
  input wire [31:0] i_host_addr,
  input wire o_host_to_dram,
  input wire o_host_to_hub,
  input wire [31:0] o_host_addr,
  input wire i_init_valid,
  input wire [31:0] i_init_addr,
  input wire o_init_claim
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // ----
  // shadow copies of the timing and hole settings
  // ----
  reg [2:0] tim_reg;
  reg hole_reg;
  wire wr_ok = i_psel && i_penable && i_pwrite && o_pready;
  wire is_act = o_sdram_cmd_valid && o_sdram_cmd == `CMD_ACTIVATE;
  wire is_rd = o_sdram_cmd_valid && o_sdram_cmd == `CMD_READ;
  wire is_rw = is_rd || (o_sdram_cmd_valid && o_sdram_cmd == `CMD_WRITE);
  wire is_pre = o_sdram_cmd_valid && o_sdram_cmd == `CMD_PRECHARGE;
  wire host_hole = i_host_valid && hole_reg && i_host_addr[31:20] == `HOLE_BASE_MB;
  wire init_hole = i_init_valid && hole_reg && i_init_addr[31:20] == `HOLE_BASE_MB;
  // follow committed register writes
  always @(posedge i_mclk) begin
    if (i_reset) begin
      tim_reg <= 3'h0;
      hole_reg <= 1'b0;
    end else if (wr_ok && i_paddr == `OFS_SDRAM_TIMING) begin
      tim_reg <= i_pwdata[2:0];
    end else if (wr_ok && i_paddr == `OFS_HOLE_CONTROL) begin
      hole_reg <= i_pwdata[`HOLE_ENABLE_BIT];
    end
  end
  // ----
  // properties
  // ----
  a_read_lat_long: assert property (is_rd && !tim_reg[2] |-> ##3 o_read_sample)
    else $error("read sample not three clocks after read");
  a_read_lat_short: assert property (is_rd && tim_reg[2] |-> ##2 o_read_sample)
    else $error("read sample not two clocks after read");
  a_act_gap_long: assert property (is_act && !tim_reg[1] |=> !is_rw [*3])
    else $error("read or write too soon after activate");
  a_act_gap_short: assert property (is_act && tim_reg[1] |=> !is_rw [*2])
    else $error("read or write too soon after activate");
  a_pre_gap_long: assert property (is_pre && !tim_reg[0] |=> !is_act [*2])
    else $error("activate too soon after precharge");
  a_pre_gap_short: assert property (is_pre && tim_reg[0] |=> !is_act)
    else $error("activate too soon after precharge");
  a_hole_host: assert property (host_hole |=> o_host_to_hub && !o_host_to_dram)
    else $error("host cycle in hole not sent to hub");
  a_hole_init: assert property (init_hole |=> !o_init_claim)
    else $error("initiator cycle in hole claimed");
  a_route_once: assert property (i_host_valid |=> o_host_to_dram != o_host_to_hub)
    else $error("host cycle not routed to exactly one target");
  a_addr_kept: assert property (i_host_valid |=> o_host_addr == $past(i_host_addr))
    else $error("host address altered on its way through");
  a_ack_pulse: assert property (o_cmd_ack |-> o_sdram_cmd_valid ##1 !o_cmd_ack)
    else $error("command acknowledge not a single pulse");
  c_read: cover property (is_rd ##2 o_read_sample);
  c_pre_act: cover property (is_pre ##2 is_act);
  c_hole: cover property (host_hole ##1 o_host_to_hub);
endmodule

bind sdram_timing_row_hole_config sdram_cfg_properties sdram_cfg_properties_i (
  .i_mclk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
  .o_cmd_ack, .o_sdram_cmd_valid, .o_sdram_cmd, .o_read_sample, .i_host_valid,
  .i_host_addr, .o_host_to_dram, .o_host_to_hub, .o_host_addr, .i_init_valid, .i_init_addr,
  .o_init_claim
);

// ===== test/sdram_module_model.sv
// behavioural sdram modules watching the command outputs
`timescale 1ns/1ps
`include "sdram_cfg_defines.vh"
module sdram_module_model (
  input wire i_mclk,
  input wire i_reset,
  input wire i_cmd_valid,
  input wire [1:0] i_cmd,
  output reg o_fault
);
  reg row_open_reg;
  wire rw = i_cmd == `CMD_READ || i_cmd == `CMD_WRITE;
  // track the open row and flag commands a real module would reject
  always @(posedge i_mclk) begin
    if (i_reset) begin
      row_open_reg <= 1'b0;
      o_fault <= 1'b0;
    end else if (i_cmd_valid) begin
      if ((i_cmd == `CMD_ACTIVATE && row_open_reg) || (rw && !row_open_reg)) begin
        o_fault <= 1'b1;
      end
      if (i_cmd == `CMD_ACTIVATE || i_cmd == `CMD_PRECHARGE) begin
        row_open_reg <= i_cmd == `CMD_ACTIVATE;
      end
    end
  end
endmodule

// ===== test/test_sdram_timing_row_hole_config.sv
// self-checking bench for the sdram timing, population and hole block
`timescale 1ns/1ps
`include "sdram_cfg_defines.vh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module test_sdram_timing_row_hole_config;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic i_cmd_valid = 1'b0;
  logic [1:0] i_cmd_code = 2'h0;
  logic i_host_valid = 1'b0;
  logic [31:0] i_host_addr = 32'h0;
  logic i_init_valid = 1'b0;
  logic [31:0] i_init_addr = 32'h0;
  wire [31:0] o_prdata, o_host_addr;
  wire [1:0] o_sdram_cmd;
  wire o_pready, o_pslverr, o_cmd_ack, o_sdram_cmd_valid, o_read_sample;
  wire o_host_to_dram, o_host_to_hub, o_init_claim, fault;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int last_cyc = 0;
  logic [2:0] tim = 3'h0;
  logic hole = 1'b0;
  logic init_seen = 1'b0;
  logic [33:0] q_apb[$], q_host[$], e, h;
  logic [9:0] q_cmd[$], k;
  logic q_init[$];
  int q_samp[$];
  logic [31:0] edge_addr [4] = '{32'h00EFFFFF, 32'h01000000, 32'h1FFFFFFF, 32'h20000000};
  logic [31:0] a, r;

  always #10 i_mclk = ~i_mclk;

  sdram_timing_row_hole_config sdram_timing_row_hole_config_i (
    .i_mclk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_cmd_valid, .i_cmd_code, .o_cmd_ack, .o_sdram_cmd_valid,
    .o_sdram_cmd, .o_read_sample, .i_host_valid, .i_host_addr, .o_host_to_dram,
    .o_host_to_hub, .o_host_addr, .i_init_valid, .i_init_addr, .o_init_claim
  );
  sdram_module_model sdram_module_model_i (.i_mclk, .i_reset,
    .i_cmd_valid(o_sdram_cmd_valid), .i_cmd(o_sdram_cmd), .o_fault(fault));

  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one apb transfer; the expected answer is queued for the monitor
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    q_apb.push_back({~w, ee, ed});
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_mclk);
  endtask

  // hold a command until acknowledged; a nonzero gap is the exact spacing expected
  task automatic cmd(input logic [1:0] c, input logic [7:0] gap);
    q_cmd.push_back({c, gap});
    i_cmd_valid <= 1'b1;
    i_cmd_code <= c;
    do @(posedge i_mclk); while (o_cmd_ack !== 1'b1);
  endtask

  // present one host and one initiator cycle at the same address
  task automatic route(input logic [31:0] ad);
    logic dram;
    dram = !(hole && ad[31:20] == `HOLE_BASE_MB) && ad < 32'h20000000;
    q_host.push_back({dram, !dram, ad});
    q_init.push_back(dram);
    i_host_valid <= 1'b1;
    i_host_addr <= ad;
    i_init_valid <= 1'b1;
    i_init_addr <= ad;
    @(posedge i_mclk);
  endtask

  // monitor: takes the oldest note whenever a result shows
  always @(posedge i_mclk) begin
    cyc++;
    if (i_psel && i_penable && o_pready === 1'b1) begin
      e = q_apb.pop_front();
      `CHK("pslverr", e[32], o_pslverr)
      if (e[33]) `CHK("prdata", e[31:0], o_prdata)
    end
    if (o_sdram_cmd_valid === 1'b1) begin
      k = q_cmd.pop_front();
      `CHK("command", k[9:8], o_sdram_cmd)
      if (k[7:0] != 8'h0) `CHK("gap", k[7:0], 8'(cyc - last_cyc))
      if (o_sdram_cmd == `CMD_READ) q_samp.push_back(cyc + (tim[2] ? 2 : 3));
      last_cyc = cyc;
    end
    if (o_read_sample === 1'b1) `CHK("sample cycle", q_samp.pop_front(), cyc)
    if (o_host_to_dram === 1'b1 || o_host_to_hub === 1'b1) begin
      h = q_host.pop_front();
      `CHK("route", h[33:32], {o_host_to_dram, o_host_to_hub})
      `CHK("host addr", h[31:0], o_host_addr)
    end
    if (init_seen) `CHK("claim", q_init.pop_front(), o_init_claim)
    init_seen = i_init_valid;
  end

  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    r = $urandom(32'h3820da77);
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    apb(1'b0, `OFS_THIRD_SOCKET_POP, 32'h0, 32'h0, 1'b0);
    apb(1'b0, `OFS_HOLE_CONTROL, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `OFS_THIRD_SOCKET_POP, 32'hFF, 32'h0, 1'b0);
    apb(1'b0, `OFS_THIRD_SOCKET_POP, 32'h0, 32'h0F, 1'b0);
    apb(1'b1, `OFS_THIRD_SOCKET_POP, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `OFS_FIRST_ROW_POP, 32'hFF, 32'h0, 1'b0);
    apb(1'b1, `OFS_THIRD_SOCKET_POP, 32'h01, 32'h0, 1'b1);
    apb(1'b0, `OFS_THIRD_SOCKET_POP, 32'h0, 32'h0, 1'b0);
    // status: 512 MB populated in the total field, not over the limit, unlocked
    apb(1'b0, `OFS_LOCK_STATUS, 32'h0, 32'h00002000, 1'b0);
    apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h44, 32'h5A, 32'h0, 1'b1);
    // every timing select combination, back-to-back commands
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `OFS_SDRAM_TIMING, i, 32'h0, 1'b0);
      apb(1'b0, `OFS_SDRAM_TIMING, 32'h0, i, 1'b0);
      tim = i[2:0];
      cmd(`CMD_ACTIVATE, 8'h0);
      cmd(`CMD_READ, tim[1] ? 8'h3 : 8'h4);
      cmd(`CMD_READ, 8'h0);
      cmd(`CMD_WRITE, 8'h0);
      cmd(`CMD_PRECHARGE, 8'h0);
      cmd(`CMD_ACTIVATE, tim[0] ? 8'h2 : 8'h3);
      cmd(`CMD_WRITE, tim[1] ? 8'h3 : 8'h4);
      cmd(`CMD_PRECHARGE, 8'h0);
      i_cmd_valid <= 1'b0;
      repeat (4) @(posedge i_mclk);
    end
    // routing with the hole on, then off
    apb(1'b1, `OFS_HOLE_CONTROL, 32'h80, 32'h0, 1'b0);
    apb(1'b0, `OFS_HOLE_CONTROL, 32'h0, 32'h80, 1'b0);
    hole = 1'b1;
    for (int i = 0; i < 48; i++) begin
      if (i == 24) begin
        i_host_valid <= 1'b0;
        i_init_valid <= 1'b0;
        @(posedge i_mclk);
        apb(1'b1, `OFS_HOLE_CONTROL, 32'h0, 32'h0, 1'b0);
        hole = 1'b0;
      end
      r = $urandom();
      a = (i % 4 == 0) ? {12'h00F, r[19:0]} : {2'b00, r[29:0]};
      if (i % 4 == 1) a = edge_addr[(i / 4) % 4];
      route(a);
    end
    i_host_valid <= 1'b0;
    i_init_valid <= 1'b0;
    // lock freezes the population register without an error
    apb(1'b1, `OFS_FIRST_ROW_POP, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `OFS_LOCK_STATUS, 32'h1, 32'h0, 1'b0);
    apb(1'b1, `OFS_THIRD_SOCKET_POP, 32'h02, 32'h0, 1'b0);
    apb(1'b0, `OFS_THIRD_SOCKET_POP, 32'h0, 32'h0, 1'b0);
    apb(1'b0, `OFS_LOCK_STATUS, 32'h0, 32'h00000001, 1'b0);
    `CHK("model fault", 1'b0, fault)
    `CHK("left over", 0, q_samp.size() + q_host.size() + q_cmd.size())
    report_and_stop();
  end
endmodule
